// File: rtl/stm_pulse_capture.sv
// Timer core for single-pulse output and capture input with an AXI4-Lite register slave.
//
// Contract
// - mode 10 with function 11 selects single pulse.
// - trigger pin edge sets on bit.
// - on rise starts counter, pulse leading edge.
// - on bit clear ends the pulse.
// - compare A match clears on bit.
// - compare A match raises interrupt request.
// - single pulse zeroes counter only on on-bit rise.
// - single pulse ignores period, clear, swap.
// - mode 01 selects capture.
// - function field picks capture edge type.
// - function 11 disables capture, counter runs.
// - capture edge copies counter into compare A.
// - capture counter free-runs while on bit high.
// - period match clears counter, raises interrupt.
// - zero period wraps at full count.
// - capture pin edges count even as output.
// - capture drives no output, ignores output bits.
// - counter and compare A are ten bits.
`timescale 1ns/1ps
module stm_pulse_capture #(
   parameter int CNT_WIDTH = stm_pkg::CNT_W
) (
   input wire logic aclk, // System clock, 125 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic ext_clock_trigger_pin, // External trigger pin, asynchronous.
   input wire logic capture_pin_a, // Capture input A, asynchronous.
   input wire logic capture_pin_b, // Capture input B, asynchronous.
   input wire logic tick_in, // Counter clock enable from the prescaler, same clock.
   output logic pulse_out, // Timer output pin level.
   output logic pulse_out_en, // High while the timer drives its output pin.
   output logic timer_irq, // One-cycle timer interrupt request.
   input wire logic [7:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [7:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready // Read data ready.
);
   import stm_pkg::*;

   logic [7:0] ctrl0;
   logic [8:0] ctrl1;
   logic timer_on;
   logic timer_on_d;
   logic [CNT_WIDTH-1:0] count;
   logic [CNT_WIDTH-1:0] compare_a_value;
   logic [2:0] trig_sync;
   logic [2:0] cap_a_sync;
   logic [2:0] cap_b_sync;
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic wr_fire;
   logic wr_ok;
   logic sw_on_set;
   logic sw_on_clr;
   logic sw_compare_a_value_wr;
   logic [1:0] op_mode;
   logic [1:0] out_function;
   logic [2:0] period_value;
   logic output_initial_control;
   logic output_polarity;
   logic pin_select;
   logic single_mode;
   logic capture_mode;
   logic on_rise;
   logic trig_edge;
   logic cap_now;
   logic cap_prev;
   logic cap_edge;
   logic match_a;
   logic match_p;
   logic period_hit;
   logic pulse_level;
   logic running;

   // Field decode; clear-select and swap bits are stored but no logic here reads them.
   // They still read back, so software that shares one setup between modes keeps working,
   // and neither mode here can be disturbed by them.
   assign op_mode = ctrl1[MODE_LSB +: 2];
   assign out_function = ctrl1[OFN_LSB +: 2];
   assign output_initial_control = ctrl1[OC_BIT];
   assign output_polarity = ctrl1[POL_BIT];
   assign pin_select = ctrl1[PINSEL_BIT];
   assign period_value = ctrl0[PER_LSB +: PER_W];
   assign single_mode = (op_mode == MODE_PWM_SP) && (out_function == OFN_SINGLE);
   assign capture_mode = (op_mode == MODE_CAPTURE);

   // Counting needs the on bit, a prescaler tick and no pause. The tick comes from logic on
   // this clock, so it is read directly; a pause freezes the count but keeps the on bit.
   assign running = timer_on && tick_in && !ctrl0[PAUSE_BIT];

   // Two-stage synchronisers plus one history stage for edge detection.
   // Logic reads only the second and third stages, never the first, which may be metastable.
   // All stages reset low, the idle level of the pins, so no false edge appears after reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_sync <= 3'h0;
         cap_a_sync <= 3'h0;
         cap_b_sync <= 3'h0;
      end else begin
         trig_sync <= {trig_sync[1:0], ext_clock_trigger_pin};
         cap_a_sync <= {cap_a_sync[1:0], capture_pin_a};
         cap_b_sync <= {cap_b_sync[1:0], capture_pin_b};
      end
   end

   // Trigger edge follows the clock-select edge choice: select 111 means falling.
   // Any other select value arms the rising edge, the more common wiring of the trigger.
   assign trig_edge = (ctrl0[CKSEL_LSB +: 3] == 3'h7) ? (trig_sync[2] && !trig_sync[1])
                                                      : (!trig_sync[2] && trig_sync[1]);
   // The pin is watched regardless of its direction elsewhere in the chip.
   assign cap_now = pin_select ? cap_b_sync[1] : cap_a_sync[1];
   assign cap_prev = pin_select ? cap_b_sync[2] : cap_a_sync[2];

   // Capture edge selection; function 11 disables capture entirely.
   // The counter does not depend on this, so it keeps running with capture disabled.
   always_comb begin
      case (out_function)
         CAP_RISE: cap_edge = cap_now && !cap_prev;
         CAP_FALL: cap_edge = !cap_now && cap_prev;
         CAP_BOTH: cap_edge = cap_now ^ cap_prev;
         default: cap_edge = 1'b0;
      endcase
   end

   // Compare A counts only for the single pulse, and never in the cycle of the on-bit rise:
   // the counter then still holds the last pulse's final count, which would end a new pulse
   // at once if it equalled compare A.
   assign match_a = single_mode && running && !on_rise && (count == compare_a_value);

   // The period value faces only the top three counter bits, so periods come in steps of
   // 128. Zero would pin the counter at zero that way, so it matches the all-ones count
   // instead and the counter wraps after the full range.
   assign period_hit = (period_value == '0) ? (count == '1)
                       : (count[CNT_WIDTH-1 -: PER_W] == period_value);
   assign match_p = capture_mode && running && period_hit;

   // AXI write channel: address and data taken in either order.
   // Both readies drop while an answer waits, so a second write cannot overtake the first.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   assign wa = aw_held ? aw_addr : s_axi_awaddr;
   assign wd = w_held ? w_data : s_axi_wdata;
   assign ws = w_held ? w_strb : s_axi_wstrb;
   // Read-only words accept a write with OKAY and ignore it; only holes in the map fail.
   assign wr_ok = (wa == CTRL0_ADDR) || (wa == CTRL1_ADDR) || (wa == COMPARE_A_VALUE_ADDR)
                  || (wa == COUNT_ADDR) || (wa == STAT_ADDR);
   assign sw_on_set = wr_fire && (wa == CTRL0_ADDR) && ws[0] && wd[TON_BIT];
   assign sw_on_clr = wr_fire && (wa == CTRL0_ADDR) && ws[0] && !wd[TON_BIT];
   assign sw_compare_a_value_wr = wr_fire && (wa == COMPARE_A_VALUE_ADDR);

   // Write response; unmapped addresses answer SLVERR.
   // The answer stands until the master shows bready, however long that takes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers, with the on bit kept apart because hardware moves it.
   // The stored copy of bit 3 is never used; reads return the live on bit instead.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0 <= CTRL0_RST;
         ctrl1 <= CTRL1_RST;
      end else if (wr_fire) begin
         if (wa == CTRL0_ADDR && ws[0]) begin
            ctrl0 <= wd[7:0];
         end
         if (wa == CTRL1_ADDR) begin
            if (ws[0]) begin
               ctrl1[7:0] <= wd[7:0];
            end
            if (ws[1]) begin
               ctrl1[8] <= wd[8];
            end
         end
      end
   end

   // On bit: hardware set from the trigger wins over a software clear in the same cycle.
   // A set also wins over a compare A match, so a trigger landing on the last count of a
   // pulse keeps it set; with no on-bit rise the count is not zeroed and the pulse runs on until it wraps round to compare A.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_on <= 1'b0;
         timer_on_d <= 1'b0;
      end else begin
         timer_on_d <= timer_on;
         if (single_mode && trig_edge) begin
            timer_on <= 1'b1;
         end else if (sw_on_set) begin
            timer_on <= 1'b1;
         end else if (match_a || sw_on_clr) begin
            timer_on <= 1'b0;
         end
      end
   end

   // The rise is seen one cycle after the on bit sets, and that cycle both zeroes the
   // counter and launches the pulse leading edge.
   assign on_rise = timer_on && !timer_on_d;

   // Counter: zeroed on the on-bit rise; capture mode also wraps on a period match.
   // When the on bit falls the residual value stays, so software can still read it; a
   // single pulse therefore leaves its final count visible until the next start.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= CNT_RST;
      end else if (on_rise) begin
         count <= CNT_RST;
      end else if (match_p && tick_in) begin
         count <= CNT_RST;
      end else if (running) begin
         count <= count + 1'b1;
      end
   end

   // Compare A register: software writes, capture edges overwrite with the count.
   // A capture wins over a write in the same cycle, since the pin event cannot be repeated
   // while a lost write can simply be issued again.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compare_a_value <= CNT_RST;
      end else if (capture_mode && timer_on && cap_edge) begin
         compare_a_value <= count;
      end else if (sw_compare_a_value_wr) begin
         if (ws[0]) begin
            compare_a_value[7:0] <= wd[7:0];
         end
         if (ws[1]) begin
            compare_a_value[CNT_WIDTH-1:8] <= wd[CNT_WIDTH-1:8];
         end
      end
   end

   // Interrupt pulse for compare A match, period match and capture.
   // Each source lasts one cycle here; the interrupt controller is expected to latch it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= match_a || (match_p && tick_in)
                      || (capture_mode && timer_on && cap_edge);
      end
   end

   // Active level one gives a high pulse while the on bit is set; the invert bit then flips
   // the whole waveform, idle level included.
   assign pulse_level = (timer_on ~^ output_initial_control) ^ output_polarity;

   // Pulse output: active while the on bit is high, shaped by active level and invert.
   // Period comparator is never consulted here, so its setting cannot shorten the pulse.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_out <= 1'b0;
         pulse_out_en <= 1'b0;
      end else begin
         pulse_out_en <= single_mode;
         pulse_out <= single_mode && pulse_level;
      end
   end

   // Read channel: one-cycle answer, mapped readbacks, SLVERR for holes.
   // Read data load only when an address is taken, so they stand as long as rvalid does.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            CTRL0_ADDR: s_axi_rdata <= {24'h000000, ctrl0[7:4], timer_on, ctrl0[2:0]};
            CTRL1_ADDR: s_axi_rdata <= {23'h000000, ctrl1};
            COUNT_ADDR: s_axi_rdata <= {{(32-CNT_WIDTH){1'b0}}, count};
            COMPARE_A_VALUE_ADDR: s_axi_rdata <= {{(32-CNT_WIDTH){1'b0}}, compare_a_value};
            STAT_ADDR: s_axi_rdata <= {30'h00000000, pulse_out, timer_on};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// File: rtl/stm_pkg.sv
// Package with register map, field positions and reset values for the pulse and capture timer.
package stm_pkg;
   localparam int CNT_W = 10;
   localparam int PER_W = 3;
   // Register byte offsets.
   localparam logic [7:0] CTRL0_ADDR = 8'h00;
   localparam logic [7:0] CTRL1_ADDR = 8'h04;
   localparam logic [7:0] COUNT_ADDR = 8'h08;
   localparam logic [7:0] COMPARE_A_VALUE_ADDR = 8'h0C;
   localparam logic [7:0] STAT_ADDR = 8'h10;
   // Control word zero fields.
   localparam int TON_BIT = 3;
   localparam int PER_LSB = 0;
   localparam int CKSEL_LSB = 4;
   localparam int PAUSE_BIT = 7;
   // Control word one fields.
   localparam int MODE_LSB = 6;
   localparam int OFN_LSB = 4;
   localparam int OC_BIT = 3;
   localparam int POL_BIT = 2;
   localparam int PINSEL_BIT = 8;
   localparam int CCLR_BIT = 0;
   localparam int DPX_BIT = 1;
   // Mode and function encodings.
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PWM_SP = 2'h2;
   localparam logic [1:0] OFN_SINGLE = 2'h3;
   localparam logic [1:0] CAP_RISE = 2'h0;
   localparam logic [1:0] CAP_FALL = 2'h1;
   localparam logic [1:0] CAP_BOTH = 2'h2;
   // Reset values and bus response codes.
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [8:0] CTRL1_RST = 9'h000;
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: tb/stm_pulse_capture_checker.sv
// Checker with bus handshake and pulse timing assertions for the pulse and capture timer.
`timescale 1ns/1ps
module stm_pulse_capture_checker (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Reset, active low.
   input wire logic ext_clock_trigger_pin, // Trigger pin.
   input wire logic pulse_out, // Pulse level.
   input wire logic pulse_out_en, // Pulse drive enable.
   input wire logic s_axi_awvalid, // Bus.
   input wire logic s_axi_awready, // Bus.
   input wire logic s_axi_wvalid, // Bus.
   input wire logic s_axi_wready, // Bus.
   input wire logic s_axi_bvalid, // Bus.
   input wire logic s_axi_bready, // Bus.
   input wire logic s_axi_arvalid, // Bus.
   input wire logic s_axi_arready, // Bus.
   input wire logic s_axi_rvalid, // Bus.
   input wire logic s_axi_rready, // Bus.
   input wire logic [31:0] s_axi_rdata // Bus.
);
   // All checks share one clock and the synchronous reset.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed");
   a_b_after_w: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write answer late");
   a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   // The bench runs single pulse active high, so an idle low output must rise after a trigger.
   a_trig_pulse: assert property (
      $rose(ext_clock_trigger_pin) && pulse_out_en && !pulse_out |-> ##[2:8] pulse_out)
      else $error("trigger gave no pulse");
   a_mode_by_write: assert property (
      $changed(pulse_out_en) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("output enable moved without a write");
endmodule
bind stm_pulse_capture stm_pulse_capture_checker u_stm_pulse_capture_checker (.aclk, .aresetn,
   .ext_clock_trigger_pin, .pulse_out, .pulse_out_en, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: tb/stm_pin_driver.sv
// Model of the pins beyond the timer: a trigger source and two capture signals.
`timescale 1ns/1ps
module stm_pin_driver (
   input wire logic aclk, // Timer clock; pins move just after its rising edge.
   output logic ext_clock_trigger_pin, // Trigger source.
   output logic capture_pin_a, // First capture signal.
   output logic capture_pin_b // Second capture signal.
);
   // Pins rest low so the first driven edge is a clean rise.
   initial begin
      ext_clock_trigger_pin = 1'b0;
      capture_pin_a = 1'b0;
      capture_pin_b = 1'b0;
   end
   // Each level is held six cycles, longer than the synchroniser, so no edge is lost.
   task automatic pulse(input int which);
      for (int v = 1; v >= 0; v--) begin
         @(posedge aclk);
         case (which)
            0: ext_clock_trigger_pin <= v[0];
            1: capture_pin_a <= v[0];
            default: capture_pin_b <= v[0];
         endcase
         repeat (5) @(posedge aclk);
      end
   endtask
endmodule

// File: tb/tb_timer_single_pulse_and_capture.sv
// Self-checking bench for single-pulse output and capture input of the timer.
`timescale 1ns/1ps
module tb_timer_single_pulse_and_capture;
   import stm_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, tick_in = 1'b1;
   logic ext_clock_trigger_pin, capture_pin_a, capture_pin_b, pulse_out, pulse_out_en, timer_irq;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   int n_mismatch = 0, n_checks = 0, n_irq = 0;
   always #4 aclk = ~aclk;
   stm_pulse_capture u_stm_pulse_capture (.aclk, .aresetn, .ext_clock_trigger_pin, .capture_pin_a,
      .capture_pin_b, .tick_in, .pulse_out, .pulse_out_en, .timer_irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   stm_pin_driver u_stm_pin_driver (.aclk, .ext_clock_trigger_pin, .capture_pin_a, .capture_pin_b);
   // Interrupt pulses are counted, since each lasts only one cycle.
   always @(posedge aclk) if (timer_irq === 1'b1) n_irq <= n_irq + 1;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Each channel is released at the edge where its ready is seen; the answer ends the task.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit done = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         done = s_axi_bvalid;
         wr_resp = s_axi_bresp;
      end
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      bit done = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         done = s_axi_rvalid;
         rd_data = s_axi_rdata;
         rd_resp = s_axi_rresp;
      end
      s_axi_rready <= 0;
   endtask
   // Sampling at the falling edge keeps clear of the register updates.
   task automatic wait_pulse(input logic v, output int n);
      for (n = 0; n < 400 && pulse_out !== v; n++) @(negedge aclk);
   endtask
   task automatic t_reset();
      rd(CTRL1_ADDR);
      chk("ctrl1", rd_data, {23'h0, CTRL1_RST});
      chk("read resp", {30'h0, rd_resp}, {30'h0, RESP_OKAY});
      rd(COUNT_ADDR);
      chk("count", rd_data, {22'h0, CNT_RST});
      rd(8'h14);
      chk("unmapped read", rd_data, 32'h0);
      chk("unmapped read resp", {30'h0, rd_resp}, {30'h0, RESP_SLVERR});
      wr(8'h14, 32'h0);
      chk("unmapped write resp", {30'h0, wr_resp}, {30'h0, RESP_SLVERR});
   endtask
   // A period of 128 must not cut a pulse of 200 counts.
   task automatic t_pulse();
      int w, irq0;
      wr(COMPARE_A_VALUE_ADDR, 32'hC8);
      chk("write resp", {30'h0, wr_resp}, {30'h0, RESP_OKAY});
      wr(CTRL1_ADDR, 32'hBB);
      irq0 = n_irq;
      wr(CTRL0_ADDR, 32'h9);
      wait_pulse(1, w);
      wait_pulse(0, w);
      chk("width", w >= 200 && w <= 203, 1);
      chk("match irq", n_irq - irq0, 1);
      rd(STAT_ADDR);
      chk("on cleared", rd_data[0], 0);
      repeat (20) @(posedge aclk);
      rd(COUNT_ADDR);
      chk("count kept", rd_data >= 200 && rd_data <= 201, 1);
   endtask
   task automatic t_trigger();
      int w;
      u_stm_pin_driver.pulse(0);
      wait_pulse(1, w);
      chk("triggered", pulse_out, 1);
      rd(COUNT_ADDR);
      chk("restart", rd_data < 32'h40, 1);
      wr(CTRL0_ADDR, 32'h0);
      wait_pulse(0, w);
      chk("early end", w <= 4, 1);
   endtask
   task automatic t_capture();
      logic [31:0] ctl [6] = '{32'h40, 32'h50, 32'h60, 32'h70, 32'h140, 32'h140};
      int exp [6] = '{1, 1, 2, 0, 0, 1};
      int irq0;
      for (int i = 0; i < 6; i++) begin
         wr(CTRL0_ADDR, 32'h0);
         wr(COMPARE_A_VALUE_ADDR, 32'h3FF);
         wr(CTRL1_ADDR, ctl[i] | 32'hF);
         wr(CTRL0_ADDR, 32'h9);
         irq0 = n_irq;
         u_stm_pin_driver.pulse((i == 5) ? 2 : 1);
         repeat (4) @(posedge aclk);
         chk("irqs", n_irq - irq0, exp[i]);
         chk("no drive", pulse_out_en, 0);
         rd(COMPARE_A_VALUE_ADDR);
         chk("captured", rd_data < 32'h40, exp[i] != 0);
      end
   endtask
   task automatic t_period();
      int irq0;
      irq0 = n_irq;
      wr(CTRL0_ADDR, 32'h0);
      wr(CTRL0_ADDR, 32'h9);
      repeat (150) @(posedge aclk);
      chk("period irq", n_irq - irq0, 1);
      rd(COUNT_ADDR);
      chk("wrapped", rd_data > 0 && rd_data < 32'h40, 1);
      wr(CTRL0_ADDR, 32'h0);
      irq0 = n_irq;
      wr(CTRL0_ADDR, 32'h8);
      repeat (600) @(posedge aclk);
      rd(COUNT_ADDR);
      chk("full range", rd_data > 32'h200 && rd_data < 32'h280, 1);
      chk("no wrap", n_irq - irq0, 0);
   endtask
   // The whole run needs about 1300 cycles, so a hang is cut at 12000.
   initial begin
      repeat (12000) @(posedge aclk);
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      t_reset();
      t_pulse();
      t_trigger();
      t_capture();
      t_period();
      summarize();
   end
endmodule
